// ===== oetc_pkg.sv
package oetc_pkg;

    // Register offsets on the plain register port
    localparam int ADDR_W = 6;
    localparam logic [5:0] TRIM_HI_ADDR = 6'h18;
    localparam logic [5:0] TRIM_LO_ADDR = 6'h19;
    localparam logic [5:0] OSC_CTRL_ADDR = 6'h1a;
    localparam logic [5:0] CLOCK_CFG_PROTECT_ADDR = 6'h1b;
    localparam logic [5:0] CLK_STAT_ADDR = 6'h1c;

    // Oscillator control fields
    localparam int OSC_EN_BIT = 7;
    localparam int OSC_RSVD_BIT = 5;
    localparam logic [7:0] OSC_CTRL_RESET = 8'h00;

    // Protection register
    localparam logic [7:0] CLOCK_CFG_PROTECT_UNLOCK_KEY = 8'h26;
    localparam logic CLOCK_CFG_PROTECT_RESET = 1'b0;

    // Trim high byte: temperature trim in 15:11, frequency trim 9:8
    localparam int TC_LSB = 3;
    localparam int TC_W = 5;
    localparam int TC_SIGN_BIT = 4;
    localparam int TC_MAG_W = 4;
    localparam int FTRIM_HI_W = 2;

    // Clock select and status register fields
    localparam int CS_PLL_CLOCK_SELECT_BIT = 0;
    localparam int CS_MONRST_BIT = 1;
    localparam int CS_STABLE_BIT = 2;
    localparam int CS_LOCK_BIT = 3;
    localparam int CS_PINRES_BIT = 4;

    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // Decoded temperature trim toward the compensation circuit
    typedef struct packed {
        logic compEnable;
        logic positive;
        logic [3:0] magnitude;
    } oetc_tc_t;

endpackage

// ===== oetc_sync.sv
`timescale 1ns/1ps
module oetc_sync (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Asynchronous level in, filtered level out
    input wire logic async,
    output logic level
);
    logic s1;
    logic s2;
    logic s3;

    // Change counts only once the second and third stages agree
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            level <= 1'b0;
        end else begin
            s1 <= async;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end
endmodule // oetc_sync

// ===== oetc_osc_ctrl.sv
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module oetc_osc_ctrl #(
    parameter int SETTLE_CYCLES = 16,
    parameter logic [7:0] TRIM_HI_RESET = 8'h03,
    parameter logic [7:0] TRIM_LO_RESET = 8'hff
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [oetc_pkg::ADDR_W-1:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrStb,
    input wire logic rdStb,
    output logic [7:0] rdData,
    // Analog status from the crystal circuit and PLL
    input wire logic oscGoodRaw,
    input wire logic pllLockRaw,
    // Clock steering
    output logic externalOscEnable,
    output logic refSelectExternal,
    output logic externalClockUsable,
    output logic crystalPinsReserved,
    output logic oscMonitorReset,
    // Trim toward the RC oscillator
    output oetc_pkg::oetc_tc_t tcTrimCtrl,
    output logic [9:0] freqTrim
);

    logic oscGood;
    logic pllLock;
    logic [7:0] oscCtrl;
    logic clockCfgProtect;
    logic pllClockSelect;
    logic oscMonitorResetEnable;
    logic oscStableFlag;
    logic pllLockFlag;
    logic [oetc_pkg::TC_W-1:0] tempCoeffTrim;
    logic [9:0] freqTrimReg;
    logic [15:0] settleCount;
    logic [15:0] lockCount;

    // Status levels come from analogue circuits on no clock of ours
    oetc_sync u_sync_osc (
        .ref_clk(ref_clk),
        .rst(rst),
        .async(oscGoodRaw),
        .level(oscGood)
    );

    oetc_sync u_sync_lock (
        .ref_clk(ref_clk),
        .rst(rst),
        .async(pllLockRaw),
        .level(pllLock)
    );

    // Address decode
    wire hitOsc = addr == oetc_pkg::OSC_CTRL_ADDR;
    wire hitProt = addr == oetc_pkg::CLOCK_CFG_PROTECT_ADDR;
    wire hitTrimHi = addr == oetc_pkg::TRIM_HI_ADDR;
    wire hitTrimLo = addr == oetc_pkg::TRIM_LO_ADDR;
    wire hitStat = addr == oetc_pkg::CLK_STAT_ADDR;

    wire oscWrOk = wrStb && hitOsc && !clockCfgProtect && pllClockSelect;
    wire trimWrOk = wrStb && (hitTrimHi || hitTrimLo) && !clockCfgProtect;
    // Trim writes with the PLL running also disturb the lock
    wire flagClear = oscWrOk || (trimWrOk && pllClockSelect);
    wire statWr = wrStb && hitStat;
    // Only enable and the reserved bit are stored; others read zero
    wire [7:0] oscWrMask = 8'(1 << oetc_pkg::OSC_EN_BIT) | 8'(1 << oetc_pkg::OSC_RSVD_BIT);

    // Settle and lock qualification counters
    wire [15:0] settleLimit = 16'(SETTLE_CYCLES);
    wire oscEnabled = oscCtrl[oetc_pkg::OSC_EN_BIT];
    wire settleDone = settleCount == settleLimit;
    wire lockDone = lockCount == settleLimit;
    wire settleRestart = flagClear || !oscGood || !oscEnabled;
    wire lockRestart = flagClear || !pllLock;
    wire [15:0] settleNext = settleCount + 16'h0001;
    wire [15:0] lockNext = lockCount + 16'h0001;
    // Flags set once, as the count reaches its limit; a level set would mask the clear
    wire settleReach = !settleRestart && !settleDone && settleNext == settleLimit;
    wire lockReach = !lockRestart && !lockDone && lockNext == settleLimit;
    wire [15:0] next_settleCount = settleRestart ? 16'h0000 :
        settleDone ? settleCount : settleNext;
    wire [15:0] next_lockCount = lockRestart ? 16'h0000 :
        lockDone ? lockCount : lockNext;
    // Loss judged against the stored enable, so the reset never outlives it
    wire oscLost = oscEnabled && oscStableFlag && !oscGood;

    // Steering decode; everything leaves through a flop
    wire next_externalClockUsable = oscStableFlag && oscEnabled;
    wire next_crystalPinsReserved = crystalPinsReserved || oscEnabled;
    wire next_oscMonitorReset = oscMonitorResetEnable && oscLost;
    // Both zero-step codes switch compensation off
    wire next_compEnable = tempCoeffTrim[oetc_pkg::TC_MAG_W-1:0] != 4'h0;
    wire next_tcPositive = tempCoeffTrim[oetc_pkg::TC_SIGN_BIT];
    wire [oetc_pkg::TC_MAG_W-1:0] next_tcMag = tempCoeffTrim[oetc_pkg::TC_MAG_W-1:0];
    wire oetc_pkg::oetc_tc_t next_tcTrimCtrl = {next_compEnable, next_tcPositive, next_tcMag};

    wire [7:0] statByte = {3'h0, crystalPinsReserved, pllLockFlag, oscStableFlag,
        oscMonitorResetEnable, pllClockSelect};
    wire [7:0] trimHiByte = {tempCoeffTrim, 1'b0, freqTrimReg[9:8]};

    // Read mux; unmapped addresses and idle cycles read zero
    logic [7:0] next_rdData;
    always_comb begin
        next_rdData = oetc_pkg::ZERO_BYTE;
        if (!rdStb) begin
            next_rdData = oetc_pkg::ZERO_BYTE;
        end else if (hitOsc) begin
            next_rdData = oscCtrl;
        end else if (hitProt) begin
            next_rdData = {7'h00, clockCfgProtect};
        end else if (hitTrimHi) begin
            next_rdData = trimHiByte;
        end else if (hitTrimLo) begin
            next_rdData = freqTrimReg[7:0];
        end else if (hitStat) begin
            next_rdData = statByte;
        end
    end

    // Registers and protection
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            oscCtrl <= oetc_pkg::OSC_CTRL_RESET;
            clockCfgProtect <= oetc_pkg::CLOCK_CFG_PROTECT_RESET;
            pllClockSelect <= 1'b0;
            oscMonitorResetEnable <= 1'b0;
            rdData <= oetc_pkg::ZERO_BYTE;
        end else begin
            rdData <= next_rdData;
            if (oscWrOk) begin
                oscCtrl <= wrData & oscWrMask;
            end
            // Protection takes every write to its own address, locked or not
            if (wrStb && hitProt) begin
                clockCfgProtect <= wrData != oetc_pkg::CLOCK_CFG_PROTECT_UNLOCK_KEY;
            end
            if (statWr) begin
                pllClockSelect <= wrData[oetc_pkg::CS_PLL_CLOCK_SELECT_BIT];
                // Monitor enable frozen while the oscillator runs
                if (!externalOscEnable) begin
                    oscMonitorResetEnable <= wrData[oetc_pkg::CS_MONRST_BIT];
                end
            end
        end
    end

    // Trim registers; reset stands in for the factory load
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            tempCoeffTrim <= TRIM_HI_RESET[7:3];
            freqTrimReg <= {TRIM_HI_RESET[1:0], TRIM_LO_RESET};
        end else if (trimWrOk && hitTrimHi) begin
            tempCoeffTrim <= wrData[oetc_pkg::TC_LSB +: oetc_pkg::TC_W];
            freqTrimReg[9:8] <= wrData[oetc_pkg::FTRIM_HI_W-1:0];
        end else if (trimWrOk) begin
            freqTrimReg[7:0] <= wrData;
        end
    end

    // Settle and lock qualification; a same-cycle clear restarts the count and blocks the set
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            settleCount <= 16'h0000;
            lockCount <= 16'h0000;
            oscStableFlag <= 1'b0;
            pllLockFlag <= 1'b0;
        end else begin
            settleCount <= next_settleCount;
            lockCount <= next_lockCount;
            if (settleReach) begin
                oscStableFlag <= 1'b1;
            end else if (flagClear || !oscGood) begin
                oscStableFlag <= 1'b0;
            end
            if (lockReach) begin
                pllLockFlag <= 1'b1;
            end else if (flagClear || !pllLock) begin
                pllLockFlag <= 1'b0;
            end
        end
    end

    // Clock steering outputs, all registered
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            externalOscEnable <= 1'b0;
            refSelectExternal <= 1'b0;
            externalClockUsable <= 1'b0;
            crystalPinsReserved <= 1'b0;
            oscMonitorReset <= 1'b0;
            tcTrimCtrl <= '0;
            freqTrim <= 10'h000;
        end else begin
            externalOscEnable <= oscEnabled;
            refSelectExternal <= oscEnabled;
            externalClockUsable <= next_externalClockUsable;
            // Sticky: pins never return to general use before reset
            crystalPinsReserved <= next_crystalPinsReserved;
            oscMonitorReset <= next_oscMonitorReset;
            tcTrimCtrl <= next_tcTrimCtrl;
            freqTrim <= freqTrimReg;
        end
    end

endmodule // oetc_osc_ctrl

// ===== oetc_osc_monitor.sv
`timescale 1ns/1ps
module oetc_osc_monitor (
    // Clock, reset, register port
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [oetc_pkg::ADDR_W-1:0] addr,
    input wire logic wrStb,
    input wire logic rdStb,
    input wire logic [7:0] rdData,
    // Watched outputs
    input wire logic externalOscEnable,
    input wire logic refSelectExternal,
    input wire logic externalClockUsable,
    input wire logic crystalPinsReserved,
    input wire logic oscMonitorReset,
    input wire oetc_pkg::oetc_tc_t tcTrimCtrl,
    input wire logic [9:0] freqTrim
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire rdCtl = rdStb && !wrStb && addr == oetc_pkg::OSC_CTRL_ADDR;
    wire rdTrim = rdStb && !wrStb && addr == oetc_pkg::TRIM_HI_ADDR;
    chk_pins_sticky: assert property (crystalPinsReserved |=> crystalPinsReserved)
        else $error("pins released");
    chk_pins_claim: assert property ($rose(externalOscEnable) |=> crystalPinsReserved)
        else $error("pins not claimed");
    chk_ref_follow: assert property (refSelectExternal == externalOscEnable)
        else $error("reference select wrong");
    chk_usable_gate: assert property (externalClockUsable |-> externalOscEnable)
        else $error("usable without enable");
    chk_monrst_gate: assert property (oscMonitorReset |-> externalOscEnable)
        else $error("monitor reset without enable");
    chk_rd_idle: assert property (!$past(rdStb) |-> rdData == 8'h00)
        else $error("read data outside slot");
    chk_rd_ctrl: assert property (rdCtl |=> rdData[7] == externalOscEnable &&
        rdData[6] == 1'b0 && rdData[4:0] == 5'h00) else $error("control readback");
    chk_rd_trim: assert property (rdTrim |=> rdData[7:3] == {tcTrimCtrl.positive,
        tcTrimCtrl.magnitude} && rdData[1:0] == freqTrim[9:8]) else $error("trim readback");
    chk_tc_off: assert property (rdTrim |=> tcTrimCtrl.compEnable == (rdData[6:3] != 4'h0))
        else $error("compensation enable wrong");
    cover property ($rose(externalClockUsable));
    cover property (oscMonitorReset);
    cover property (rdTrim);
endmodule // oetc_osc_monitor
bind oetc_osc_ctrl oetc_osc_monitor mon (.ref_clk, .rst, .addr, .wrStb, .rdStb, .rdData,
    .externalOscEnable, .refSelectExternal, .externalClockUsable, .crystalPinsReserved,
    .oscMonitorReset, .tcTrimCtrl, .freqTrim);

// ===== oetc_crystal_out_pin_model.sv
`timescale 1ns/1ps
module oetc_crystal_out_pin_model #(parameter int STARTUP = 6) (
    // Clock and controls
    input wire logic ref_clk,
    input wire logic enable,
    input wire logic lose,
    // Status levels
    output logic oscGood,
    output logic pllLock
);
    int count = 0;
    initial {oscGood, pllLock} = 2'b00;
    // Start-up delay that software must wait out
    always @(posedge ref_clk) begin
        count <= (enable && !lose) ? count + 1 : 0;
        oscGood <= count >= STARTUP;
        pllLock <= oscGood;
    end
endmodule // oetc_crystal_out_pin_model

// ===== tb.sv
`timescale 1ns/1ps
module tb;
    logic ref_clk = 0, rst = 1, wrStb = 0, rdStb = 0, lose = 0, oscGood, pllLock;
    logic [oetc_pkg::ADDR_W-1:0] addr = 6'h00;
    logic [7:0] wrData = 8'h00, rdData, b;
    logic externalOscEnable, refSelectExternal, externalClockUsable;
    logic crystalPinsReserved, oscMonitorReset;
    oetc_pkg::oetc_tc_t tcTrimCtrl;
    logic [9:0] freqTrim;
    logic [7:0] corner [4] = '{8'h00, 8'h80, 8'hf8, 8'h08};
    int fail_count = 0, compares = 0, cycles = 0, seed = 32'h8f5eabd4;
    oetc_osc_ctrl #(.SETTLE_CYCLES(2)) uut (.ref_clk, .rst, .addr, .wrData, .wrStb, .rdStb,
        .rdData, .oscGoodRaw(oscGood), .pllLockRaw(pllLock), .externalOscEnable,
        .refSelectExternal, .externalClockUsable, .crystalPinsReserved, .oscMonitorReset,
        .tcTrimCtrl, .freqTrim);
    oetc_crystal_out_pin_model crystal_out_pin (.ref_clk, .enable(externalOscEnable), .lose, .oscGood, .pllLock);
    initial forever #10 ref_clk = ~ref_clk;
    task automatic report_and_stop;
        if (fail_count == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic chk(input string name, input logic [9:0] seen, input logic [9:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        {addr, wrData, wrStb} <= {a, d, 1'b1};
        @(posedge ref_clk);
        wrStb <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        {addr, rdStb} <= {a, 1'b1};
        @(posedge ref_clk);
        rdStb <= 1'b0;
        #1 chk("rdData", rdData, exp);
    endtask
    // Bounded wait, the settle time depends on the synchroniser; looks off the edge
    task automatic wait_hi(ref logic s);
        for (int n = 0; n < 80 && s !== 1'b1; n++) begin
            @(posedge ref_clk);
            #1;
        end
    endtask
    function automatic logic [9:0] exp_tc(input logic [7:0] v);
        return {4'h0, v[6:3] != 4'h0, v[7], v[6:3]};
    endfunction
    initial begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        rd(oetc_pkg::OSC_CTRL_ADDR, 8'h00);
        rd(6'h3f, 8'h00);
        wr(oetc_pkg::OSC_CTRL_ADDR, 8'h80);
        rd(oetc_pkg::OSC_CTRL_ADDR, 8'h00);
        wr(oetc_pkg::CLK_STAT_ADDR, 8'h03);
        wr(oetc_pkg::CLOCK_CFG_PROTECT_ADDR, 8'h11);
        rd(oetc_pkg::CLOCK_CFG_PROTECT_ADDR, 8'h01);
        wr(oetc_pkg::OSC_CTRL_ADDR, 8'h80);
        rd(oetc_pkg::OSC_CTRL_ADDR, 8'h00);
        wr(oetc_pkg::CLOCK_CFG_PROTECT_ADDR, 8'h26);
        rd(oetc_pkg::CLOCK_CFG_PROTECT_ADDR, 8'h00);
        for (int i = 0; i < 12; i++) begin
            b = i < 4 ? corner[i] : 8'($random(seed));
            wr(oetc_pkg::TRIM_HI_ADDR, b);
            wr(oetc_pkg::TRIM_LO_ADDR, b);
            @(posedge ref_clk);
            #1 chk("tcTrimCtrl", tcTrimCtrl, exp_tc(b));
            chk("freqTrim", freqTrim, {b[1:0], b});
            rd(oetc_pkg::TRIM_HI_ADDR, b & 8'hfb);
        end
        wr(oetc_pkg::OSC_CTRL_ADDR, 8'h80);
        rd(oetc_pkg::OSC_CTRL_ADDR, 8'h80);
        chk("pins", crystalPinsReserved, 1'b1);
        chk("refSel", refSelectExternal, 1'b1);
        chk("oscEn", externalOscEnable, 1'b1);
        wait_hi(externalClockUsable);
        chk("usable", externalClockUsable, 1'b1);
        wr(oetc_pkg::OSC_CTRL_ADDR, 8'h80);
        @(posedge ref_clk);
        #1 chk("usable", externalClockUsable, 1'b0);
        wait_hi(externalClockUsable);
        lose <= 1'b1;
        wait_hi(oscMonitorReset);
        chk("monRst", oscMonitorReset, 1'b1);
        lose <= 1'b0;
        wr(oetc_pkg::OSC_CTRL_ADDR, 8'h00);
        @(posedge ref_clk);
        #1 chk("refSel", refSelectExternal, 1'b0);
        chk("oscEn", externalOscEnable, 1'b0);
        chk("pins", crystalPinsReserved, 1'b1);
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 chk("pins", crystalPinsReserved, 1'b0);
        report_and_stop();
    end
endmodule // tb
